// file: ids_consts.vh
`ifndef IDS_CONSTS_VH
`define IDS_CONSTS_VH
// ==========================================================
// configuration record
`define IDS_CFG_REC_NUM 8'h7F
`define IDS_CFG_DIAG_EN_BIT 0
`define IDS_CFG_COMBINED_BIT 1
// ==========================================================
// diagnostic record byte indices
`define IDS_REC_BYTE0 4'h0
`define IDS_REC_BYTE1 4'h1
`define IDS_REC_BYTE2 4'h2
`define IDS_REC_BYTE3 4'h3
`define IDS_REC_BASIC_BYTES 4
`define IDS_REC_EXT_BYTES 12
// ==========================================================
// diagnostic byte field positions
`define IDS_B0_MODULE_FAIL 0
`define IDS_B0_INT_ERR 1
`define IDS_B0_EXT_ERR 2
`define IDS_B0_CHAN_ERR 3
`define IDS_B0_EXT_SUPPLY 4
`define IDS_B1_CHAN_INFO 4
`define IDS_B2_INT_SUPPLY 4
`define IDS_B3_LOST_IRQ 6
`define IDS_CLASS_DIGITAL 4'hF
`define IDS_CLASS_FUNCTION 4'h8
// ==========================================================
// queue entry layout
`define IDS_QE_W 4
`define IDS_QE_TYPE 3
`define IDS_QE_OUT 2
`define IDS_QE_CH_HI 1
`define IDS_QE_CH_LO 0
// ==========================================================
// reset values
`define IDS_REC_RESET 32'h0000_0000
`define IDS_CFG_RESET 2'h0
`endif

// file: ids_handler_model.sv
`default_nettype none
module ids_handler_model (
    // clock, reset, handler entry, run lengths
    input wire logic clk,
    input wire logic resetn,
    input wire logic proc_start,
    input wire logic proc_preempt,
    input wire logic diag_start,
    input wire logic [7:0] pdly,
    input wire logic [7:0] ddly,
    // completion and record fetch
    output logic proc_done,
    output logic diag_done,
    output logic rec_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    int pc;
    int dc;
    // ==========================================
    // handler engine, aborted handler never resumes
    always @(negedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pc <= 0;
            dc <= 0;
            proc_done <= 1'b0;
            diag_done <= 1'b0;
            rec_rd <= 1'b0;
        end
        else
        begin
            proc_done <= (pc == 1) && !proc_preempt;
            diag_done <= (dc == 1);
            rec_rd <= diag_start;
            if (proc_preempt || proc_start)
                pc <= proc_preempt ? 0 : int'(pdly);
            else if (pc > 0)
                pc <= pc - 1;
            if (diag_start)
                dc <= int'(ddly);
            else if (dc > 0)
                dc <= dc - 1;
        end
    end
endmodule
`default_nettype wire

// file: ids_seq_props.sv
`default_nettype none
module ids_seq_props #(
    parameter NUM_CH = 4,
    parameter [15:0] MODULE_ADDR = 16'h0100
) (
    // clock, reset, configuration, events
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_rec_num,
    input wire logic [7:0] cfg_data,
    input wire logic [NUM_CH-1:0] meas_end,
    // handler link
    input wire logic proc_start,
    input wire logic [1:0] proc_ch,
    input wire logic [31:0] proc_event_dword,
    input wire logic proc_preempt,
    input wire logic proc_done,
    input wire logic diag_start,
    input wire logic diag_outgoing,
    input wire logic [31:0] diag_event_dword,
    input wire logic diag_done,
    // indicator and log
    input wire logic system_fault_indicator,
    input wire logic log_valid,
    input wire logic [7:0] log_cause,
    input wire logic [15:0] log_addr,
    input wire logic log_outgoing
);
    timeunit 1ns;
    timeprecision 1ns;
    logic en_r, comb_r, run_r, busy_r;
    // ==========================================
    // shadow of config and handler state
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_r <= 1'b0;
            comb_r <= 1'b0;
            run_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cfg_wr && cfg_rec_num == 8'h7F)
            begin
                en_r <= cfg_data[0];
                comb_r <= cfg_data[1];
            end
            run_r <= proc_start | (run_r & ~proc_done & ~proc_preempt);
            busy_r <= diag_start | (busy_r & ~diag_done);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn || !clk_en);
    // ==========================================
    // properties
    AST_EVENT_BYTE: assert property (proc_start |-> proc_event_dword == (32'h1 << (8 * proc_ch)))
        else $error("process event byte wrong");
    AST_DIAG_ENABLED: assert property (diag_start |-> en_r)
        else $error("diagnostic raised while disabled");
    AST_RECUR: assert property (run_r && !proc_done && !diag_start && en_r && comb_r && !busy_r
        && meas_end[proc_ch] |=> diag_start && proc_preempt && !diag_outgoing)
        else $error("recurrence did not preempt");
    AST_HOLD: assert property (busy_r |-> !proc_start)
        else $error("process started during diagnostic");
    AST_FIXED_ZERO: assert property (diag_start |->
        (diag_event_dword & 32'hBFEF_00E0) == 32'h0)
        else $error("fixed zero record bits set");
    AST_LOG: assert property ((diag_start || log_valid) |-> diag_start && log_valid
        && log_addr == MODULE_ADDR && log_outgoing == diag_outgoing && log_cause == diag_event_dword[7:0])
        else $error("log entry mismatch");
    AST_FAULT_LIT: assert property (diag_start && !diag_outgoing |-> ##[0:2] system_fault_indicator)
        else $error("indicator not lit");
    AST_OUT_NO_PREEMPT: assert property (diag_outgoing && diag_start |-> !proc_preempt && $past(!busy_r))
        else $error("outgoing diagnostic out of place");
    cover property (diag_start && proc_preempt);
    cover property (diag_start && diag_outgoing);
    cover property (proc_start && proc_ch == 2'h3);
endmodule
bind ids_sequencer ids_seq_props #(.NUM_CH(NUM_CH), .MODULE_ADDR(MODULE_ADDR)) i_props (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rec_num(cfg_rec_num), .cfg_data(cfg_data), .meas_end(meas_end),
    .proc_start(proc_start), .proc_ch(proc_ch), .proc_event_dword(proc_event_dword), .proc_preempt(proc_preempt),
    .proc_done(proc_done), .diag_start(diag_start), .diag_outgoing(diag_outgoing),
    .diag_event_dword(diag_event_dword), .diag_done(diag_done), .system_fault_indicator(system_fault_indicator),
    .log_valid(log_valid), .log_cause(log_cause), .log_addr(log_addr), .log_outgoing(log_outgoing));
`default_nettype wire

// file: ids_sequencer.v
`include "ids_consts.vh"
`default_nettype none
module ids_sequencer #(
    parameter NUM_CH = 4,
    parameter QDEPTH = 8,
    parameter QAW = 3,
    parameter [15:0] MODULE_ADDR = 16'h0100
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    input wire clk_en,
    // configuration record write
    input wire cfg_wr,
    input wire [7:0] cfg_rec_num,
    input wire [7:0] cfg_data,
    // measurement and fault sources
    input wire [NUM_CH-1:0] meas_end,
    input wire ext_supply_missing,
    input wire int_supply_missing,
    input wire output_overload,
    input wire function_module,
    input wire [8*`IDS_REC_EXT_BYTES-1:0] module_diag_data,
    // process handler link
    output reg proc_start,
    output reg [1:0] proc_ch,
    output reg [31:0] proc_event_dword,
    output reg proc_preempt,
    input wire proc_done,
    // diagnostic handler link
    output reg diag_start,
    output reg diag_outgoing,
    output reg [31:0] diag_event_dword,
    input wire diag_done,
    // record read service
    input wire rec_rd,
    input wire [3:0] rec_idx,
    output reg [7:0] rec_data,
    // indicator and log
    output reg system_fault_indicator,
    output reg log_valid,
    output reg [7:0] log_cause,
    output reg [15:0] log_addr,
    output reg log_outgoing
);

// ==========================================================
// states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_PROC = 3'b010;
localparam [2:0] ST_DIAG = 3'b100;

// ==========================================================
// record assembly
function [31:0] mk_rec;
    input lost, ext_s, int_s, ovl, fmod;
    reg [7:0] b0, b1, b2, b3;
    begin
        b0 = 8'h00;
        b1 = 8'h00;
        b2 = 8'h00;
        b3 = 8'h00;
        b0[`IDS_B0_MODULE_FAIL] = lost | ext_s | int_s | ovl;
        b0[`IDS_B0_INT_ERR] = int_s | ovl;
        b0[`IDS_B0_EXT_ERR] = ext_s;
        b0[`IDS_B0_CHAN_ERR] = ext_s;
        b0[`IDS_B0_EXT_SUPPLY] = ext_s;
        b1[3:0] = fmod ? `IDS_CLASS_FUNCTION : `IDS_CLASS_DIGITAL;
        b1[`IDS_B1_CHAN_INFO] = lost | ext_s | int_s | ovl;
        b2[`IDS_B2_INT_SUPPLY] = int_s;
        b3[`IDS_B3_LOST_IRQ] = lost;
        mk_rec = {b3, b2, b1, b0};
    end
endfunction

// ==========================================================
// declarations
reg [2:0] state_r;
reg [1:0] cfg_r;
reg [NUM_CH-1:0] pend_r;
reg [NUM_CH-1:0] affected_r;
reg [NUM_CH-1:0] outpend_r;
reg [2:0] faults_r;
reg [31:0] rec_r;
reg [1:0] run_ch_r;
reg [`IDS_QE_W-1:0] q_mem_r [0:QDEPTH-1];
reg [QAW-1:0] q_wp_r;
reg [QAW-1:0] q_rp_r;
reg [QAW:0] q_cnt_r;
wire diag_en = cfg_r[`IDS_CFG_DIAG_EN_BIT];
wire combined = cfg_r[`IDS_CFG_COMBINED_BIT];
wire [2:0] faults_now = {output_overload, int_supply_missing, ext_supply_missing};
wire fault_rise = |(faults_now & ~faults_r);
wire fault_fall = |(~faults_now & faults_r);
wire fault_evt = fault_rise | fault_fall;
wire [NUM_CH-1:0] evt_ok = combined ? (meas_end & ~affected_r) : {NUM_CH{1'b0}};
wire recur = state_r[1] & evt_ok[run_ch_r];
wire q_empty = (q_cnt_r == {(QAW+1){1'b0}});
wire q_full = (q_cnt_r == QDEPTH[QAW:0]);
wire [`IDS_QE_W-1:0] q_head = q_mem_r[q_rp_r];
wire [31:0] live_rec = mk_rec(1'b0, faults_now[0], faults_now[1], faults_now[2], function_module);
wire [31:0] lost_rec = mk_rec(1'b1, faults_now[0], faults_now[1], faults_now[2], function_module);

// ==========================================================
// lowest pending channel
reg [1:0] pick_ch, out_ch;
reg pick_any, out_any;
integer i;
always @*
begin
    pick_ch = 2'h0;
    pick_any = 1'b0;
    out_ch = 2'h0;
    out_any = 1'b0;
    for (i = NUM_CH - 1; i >= 0; i = i - 1)
    begin
        if (pend_r[i])
        begin
            pick_ch = i[1:0];
            pick_any = 1'b1;
        end
        if (pend_r[i] && outpend_r[i])
        begin
            out_ch = i[1:0];
            out_any = 1'b1;
        end
    end
end

// ==========================================================
// queue push and pop decisions
reg q_push;
reg [`IDS_QE_W-1:0] q_push_d;
reg q_pop;
reg [NUM_CH-1:0] held_proc;
always @*
begin
    q_push = 1'b0;
    q_push_d = {`IDS_QE_W{1'b0}};
    held_proc = state_r[2] ? evt_ok : {NUM_CH{1'b0}};
    q_pop = state_r[0] && !q_empty;
    // fault edge not servable this cycle waits in the fifo, and is dropped if the fifo is full
    if ((state_r[2] || (state_r[0] && (!q_empty || out_any))) && fault_evt && diag_en && !q_full)
    begin
        q_push = 1'b1;
        q_push_d[`IDS_QE_TYPE] = 1'b1;
        q_push_d[`IDS_QE_OUT] = fault_fall & ~fault_rise;
    end
end

// ==========================================================
// held-event fifo
genvar g;
generate
    for (g = 0; g < QDEPTH; g = g + 1)
    begin : g_q
        localparam integer SLOT = g;
        always @(posedge clk or negedge resetn)
        begin
            if (!resetn)
                q_mem_r[g] <= {`IDS_QE_W{1'b0}};
            else if (clk_en && q_push && q_wp_r == SLOT[QAW-1:0])
                q_mem_r[g] <= q_push_d;
        end
    end
endgenerate

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        q_wp_r <= {QAW{1'b0}};
        q_rp_r <= {QAW{1'b0}};
        q_cnt_r <= {(QAW+1){1'b0}};
    end
    else if (clk_en)
    begin
        if (q_push)
            q_wp_r <= q_wp_r + 1'b1;
        if (q_pop)
            q_rp_r <= q_rp_r + 1'b1;
        if (q_push && !q_pop)
            q_cnt_r <= q_cnt_r + 1'b1;
        else if (q_pop && !q_push)
            q_cnt_r <= q_cnt_r - 1'b1;
    end
end

// ==========================================================
// sequencer
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        state_r <= ST_IDLE;
        cfg_r <= `IDS_CFG_RESET;
        pend_r <= {NUM_CH{1'b0}};
        affected_r <= {NUM_CH{1'b0}};
        outpend_r <= {NUM_CH{1'b0}};
        faults_r <= 3'h0;
        rec_r <= `IDS_REC_RESET;
        run_ch_r <= 2'h0;
        proc_start <= 1'b0;
        proc_ch <= 2'h0;
        proc_event_dword <= 32'h0000_0000;
        proc_preempt <= 1'b0;
        diag_start <= 1'b0;
        diag_outgoing <= 1'b0;
        diag_event_dword <= 32'h0000_0000;
        system_fault_indicator <= 1'b0;
        log_valid <= 1'b0;
        log_cause <= 8'h00;
        log_addr <= 16'h0000;
        log_outgoing <= 1'b0;
    end
    else if (clk_en)
    begin
        proc_start <= 1'b0;
        proc_preempt <= 1'b0;
        diag_start <= 1'b0;
        log_valid <= 1'b0;
        faults_r <= faults_now;
        if (cfg_wr && cfg_rec_num == `IDS_CFG_REC_NUM)
            cfg_r <= {cfg_data[`IDS_CFG_COMBINED_BIT], cfg_data[`IDS_CFG_DIAG_EN_BIT]};
        if (fault_evt)
            rec_r <= live_rec;
        if (recur)
            rec_r <= lost_rec;
        system_fault_indicator <= (|affected_r) | (|faults_r);
        case (state_r)
            ST_IDLE:
            begin
                pend_r <= pend_r | evt_ok;
                if (q_pop && q_head[`IDS_QE_TYPE])
                begin
                    state_r <= ST_DIAG;
                    diag_start <= 1'b1;
                    diag_outgoing <= q_head[`IDS_QE_OUT];
                    diag_event_dword <= live_rec;
                    log_valid <= 1'b1;
                    log_cause <= live_rec[7:0];
                    log_addr <= MODULE_ADDR;
                    log_outgoing <= q_head[`IDS_QE_OUT];
                end
                else if (q_pop)
                    pend_r[q_head[`IDS_QE_CH_HI:`IDS_QE_CH_LO]] <= 1'b1;
                else if (out_any)
                begin
                    state_r <= ST_DIAG;
                    outpend_r[out_ch] <= 1'b0;
                    affected_r[out_ch] <= 1'b0;
                    diag_start <= 1'b1;
                    diag_outgoing <= 1'b1;
                    diag_event_dword <= rec_r;
                    log_valid <= 1'b1;
                    log_cause <= rec_r[7:0];
                    log_addr <= MODULE_ADDR;
                    log_outgoing <= 1'b1;
                end
                else if (fault_evt && diag_en)
                begin
                    state_r <= ST_DIAG;
                    diag_start <= 1'b1;
                    diag_outgoing <= fault_fall & ~fault_rise;
                    diag_event_dword <= live_rec;
                    log_valid <= 1'b1;
                    log_cause <= live_rec[7:0];
                    log_addr <= MODULE_ADDR;
                    log_outgoing <= fault_fall & ~fault_rise;
                end
                else if (pick_any)
                begin
                    state_r <= ST_PROC;
                    pend_r[pick_ch] <= 1'b0;
                    run_ch_r <= pick_ch;
                    proc_start <= 1'b1;
                    proc_ch <= pick_ch;
                    proc_event_dword <= 32'h0000_0000;
                    proc_event_dword[{pick_ch, 3'b000}] <= 1'b1;
                end
            end
            ST_PROC:
            begin
                pend_r <= pend_r | (evt_ok & ~({{(NUM_CH-1){1'b0}}, 1'b1} << run_ch_r));
                if ((recur || fault_evt) && diag_en)
                begin
                    state_r <= ST_DIAG;
                    proc_preempt <= 1'b1;
                    diag_start <= 1'b1;
                    diag_outgoing <= ~recur & fault_fall & ~fault_rise;
                    diag_event_dword <= recur ? lost_rec : live_rec;
                    log_valid <= 1'b1;
                    log_cause <= recur ? lost_rec[7:0] : live_rec[7:0];
                    log_addr <= MODULE_ADDR;
                    log_outgoing <= ~recur & fault_fall & ~fault_rise;
                    if (recur)
                    begin
                        affected_r[run_ch_r] <= 1'b1;
                        outpend_r[run_ch_r] <= 1'b1;
                        pend_r[run_ch_r] <= 1'b1;
                    end
                end
                else if (proc_done)
                    state_r <= ST_IDLE;
            end
            ST_DIAG:
            begin
                pend_r <= pend_r | held_proc;
                if (diag_done)
                    state_r <= ST_IDLE;
            end
            default:
                state_r <= ST_IDLE;
        endcase
    end
end

// ==========================================================
// record read service
reg [7:0] rec_byte;
always @*
begin
    rec_byte = 8'h00;
    if (rec_idx < `IDS_REC_BASIC_BYTES)
        rec_byte = rec_r[{rec_idx[1:0], 3'b000} +: 8];
    else
        rec_byte = module_diag_data[{rec_idx - 4'h4, 3'b000} +: 8];
end

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        rec_data <= 8'h00;
    else if (clk_en && rec_rd)
        rec_data <= rec_byte;
end

endmodule
`default_nettype wire

// file: test_io_diag_interrupt_sequencer.sv
`default_nettype none
module test_io_diag_interrupt_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [95:0] MDATA = 96'hB1A2_9384_7566_5748_3A2B_1C0D;
    logic clk, resetn = 1'b0, cfg_wr = 1'b0, ext_s = 1'b0, int_s = 1'b0, fmod = 1'b0, tb_rd = 1'b0;
    logic ce = 1'b1, ovl = 1'b0;
    logic [7:0] cfg_num = 8'h00, cfg_dat = 8'h00, pdly = 8'h03, ddly = 8'h0C, rdat, lc, c;
    logic [3:0] me = 4'h0, tb_idx = 4'h0;
    logic [1:0] pch;
    logic [31:0] pdw, ddw, d;
    logic [15:0] la;
    logic ps, pp, ds, dout, sfi, lv, lo, m_rd, p_done, d_done;
    logic [7:0] evc[$];
    logic [31:0] evd[$];
    int bad_count = 0, compares = 0, cyc = 0;
    ids_sequencer i_dut (.clk(clk), .resetn(resetn), .clk_en(ce), .cfg_wr(cfg_wr), .cfg_rec_num(cfg_num),
        .cfg_data(cfg_dat), .meas_end(me), .ext_supply_missing(ext_s), .int_supply_missing(int_s),
        .output_overload(ovl), .function_module(fmod), .module_diag_data(MDATA), .proc_start(ps), .proc_ch(pch),
        .proc_event_dword(pdw), .proc_preempt(pp), .proc_done(p_done), .diag_start(ds), .diag_outgoing(dout),
        .diag_event_dword(ddw), .diag_done(d_done), .rec_rd(tb_rd | m_rd), .rec_idx(m_rd ? 4'h0 : tb_idx),
        .rec_data(rdat), .system_fault_indicator(sfi), .log_valid(lv), .log_cause(lc), .log_addr(la),
        .log_outgoing(lo));
    ids_handler_model i_host (.clk(clk), .resetn(resetn), .proc_start(ps), .proc_preempt(pp), .diag_start(ds),
        .pdly(pdly), .ddly(ddly), .proc_done(p_done), .diag_done(d_done), .rec_rd(m_rd));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================
    // handler entry monitor and timeout
    always @(negedge clk)
    begin
        if (ds || lv)
            chk("log_entry", {ds, dout, 16'h0100}, {lv, lo, la});
        if (ds)
        begin
            evc.push_back({5'h02, pp, dout, 1'b0});
            evd.push_back(ddw);
        end
        else if (ps)
        begin
            evc.push_back({6'h08, pch});
            evd.push_back(pdw);
        end
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            report_and_stop;
        end
    end
    // ==========================================
    // shared tasks
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task pulse(input logic [3:0] m);
        @(negedge clk);
        me = m;
        @(negedge clk);
        me = 4'h0;
    endtask
    task cfg(input logic [7:0] n, input logic [7:0] v);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_num = n;
        cfg_dat = v;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task rd(input logic [3:0] i);
        @(negedge clk);
        tb_rd = 1'b1;
        tb_idx = i;
        @(negedge clk);
        tb_rd = 1'b0;
        c = rdat;
    endtask
    task get_ev;
        c = 8'h00;
        for (int k = 0; k < 150 && evc.size() == 0; k++)
            @(negedge clk);
        if (evc.size() > 0)
        begin
            c = evc.pop_front();
            d = evd.pop_front();
        end
    endtask
    // ==========================================
    // scenarios
    task t_gate;
        pulse(4'h1);
        cfg(8'h7E, 8'h03);
        pulse(4'h1);
        tick(10);
        chk("gated", 32'h0, evc.size());
    endtask
    task t_bytes;
        cfg(8'h7F, 8'h02);
        pulse(4'hF);
        for (int k = 0; k < 4; k++)
        begin
            get_ev;
            chk("proc_code", 8'h20 | k, c);
            chk("proc_dword", 32'h1 << (8 * k), d);
        end
        tick(10);
        ce = 1'b0;
        pulse(4'h1);
        tick(5);
        ce = 1'b1;
        tick(10);
        chk("frozen", 32'h0, evc.size());
    endtask
    task t_recur_off;
        pdly = 8'h1E;
        pulse(4'h2);
        get_ev;
        pulse(4'h2);
        tick(80);
        foreach (evc[k])
            chk("no_diag", 1'b0, evc[k][4]);
        evc.delete();
        evd.delete();
        rd(4'h3);
        chk("kept_byte3", 8'h40, c);
    endtask
    task t_recur_on;
        int po, p2, p3;
        po = -1;
        p2 = -1;
        p3 = -1;
        cfg(8'h7F, 8'h03);
        pdly = 8'h28;
        pulse(4'h4);
        get_ev;
        pulse(4'h4);
        get_ev;
        chk("incoming", 8'h14, c);
        chk("lost_byte3", 8'h40, d[31:24]);
        chk("class_info", 5'h1F, d[12:8]);
        int_s = 1'b1;
        pulse(4'hC);
        tick(2);
        chk("lit", 1'b1, sfi);
        get_ev;
        chk("held_diag", 8'h10, c);
        chk("int_supply", 32'h0010_0002, d & 32'h00FF_0002);
        for (int k = 0; k < 3; k++)
        begin
            get_ev;
            po = (c === 8'h12) ? k : po;
            p2 = (c === 8'h22) ? k : p2;
            p3 = (c === 8'h23) ? k : p3;
        end
        chk("replay", 1'b1, po >= 0 && po < p2 && p3 >= 0);
        tick(100);
        chk("dropped", 32'h0, evc.size());
        fmod = 1'b1;
        tick(3);
        int_s = 1'b0;
        get_ev;
        chk("outgoing", 8'h12, c);
        chk("fn_class", 4'h8, d[11:8]);
        tick(20);
        chk("unlit", 1'b0, sfi);
    endtask
    task t_ext_read;
        ext_s = 1'b1;
        get_ev;
        chk("ext_bits", 8'h1C, d[7:0] & 8'h1C);
        tick(20);
        ext_s = 1'b0;
        tick(30);
        rd(4'h4);
        chk("ext_first", MDATA[7:0], c);
        rd(4'hF);
        chk("ext_last", MDATA[95:88], c);
        evc.delete();
        evd.delete();
        ovl = 1'b1;
        get_ev;
        chk("ovl_bits", 32'h0000_1003, d & 32'h0000_10FF);
        ovl = 1'b0;
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        tick(4);
        resetn = 1'b1;
        t_gate;
        t_bytes;
        t_recur_off;
        t_recur_on;
        t_ext_read;
        report_and_stop;
    end
endmodule
`default_nettype wire
